/* verilog/emp_decode.sv */
`timescale 1ns/1ps
`include "emp_params.svh"
module emp_decode
  import emp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic [15:0] io_addr_i,
  input  wire logic [7:0]  io_wdata_i,
  input  wire logic [27:0] mem_addr_i,
  input  wire logic        mem_wr_i,
  output logic      [7:0]  io_rdata_o,
  output logic      [27:0] phys_addr_o,
  output logic             win_hit_o,
  output logic             dram_sel_o,
  output logic             rom_sel_o,
  output logic             cacheable_o
);

  // ****************************************************************
  // Configuration state
  // ****************************************************************
  logic [7:0]  idx_reg;
  logic [7:0]  ram_adr_reg;
  logic [7:0]  xfr_reg;
  logic [7:0]  xfr_next;
  logic [7:0]  ctl_reg;
  logic [7:0]  nclo_reg;
  logic [7:0]  nchi_reg;
  logic [7:0]  src_val;
  emp_desc_t   desc_reg [`EMP_PAGES];

  emp_reg_if   etr_if [`EMP_ETRS] ();
  emp_reg_if   ucl_if ();
  emp_reg_if   tm_if ();
  emp_reg_if   trm_if ();
  emp_blk_t    etr_q [`EMP_ETRS];

  // ****************************************************************
  // I/O port decode
  // ****************************************************************
  wire         wr_idx  = io_wr_i && (io_addr_i == `EMP_PORT_IDX);
  wire         wr_dat  = io_wr_i && (io_addr_i == `EMP_PORT_DAT);
  wire         rd_dat  = io_rd_i && (io_addr_i == `EMP_PORT_DAT);
  wire         go      = wr_dat && (idx_reg == `EMP_IDX_CTL) && io_wdata_i[`EMP_CTL_GO];
  wire         go_wr   = go && io_wdata_i[`EMP_CTL_WR];
  wire         go_rd   = go && !io_wdata_i[`EMP_CTL_WR];
  wire [3:0]   dst     = io_wdata_i[3:0];

  // Table locations outside the page range are simply not written.
  wire         ram_ok  = (ram_adr_reg >= `EMP_RAM_BASE) && (ram_adr_reg <= `EMP_RAM_TOP);
  wire [7:0]   ram_off = ram_adr_reg - `EMP_RAM_BASE;
  wire [4:0]   ram_pg  = ram_off[4:0];
  // The base is a multiple of four, so the low bits pick the shared entry.
  wire [1:0]   etr_sel = ram_off[1:0];

  wire         we_desc = go_wr && ram_ok && (dst == `EMP_DST_DESC);
  wire         we_elo  = go_wr && ram_ok && (dst == `EMP_DST_ETR_LO);
  wire         we_ehi  = go_wr && ram_ok && (dst == `EMP_DST_ETR_HI);

  // ****************************************************************
  // Index, staging and static table registers
  // ****************************************************************
  // Index and staging registers follow port writes; transfers use staged data.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      idx_reg     <= `EMP_BYTE_RST;
      ram_adr_reg <= `EMP_BYTE_RST;
      xfr_reg     <= `EMP_BYTE_RST;
      ctl_reg     <= `EMP_BYTE_RST;
    end
    else
    begin
      if (wr_idx)
      begin
        idx_reg <= io_wdata_i;
      end
      if (wr_dat && (idx_reg == `EMP_IDX_ADR))
      begin
        ram_adr_reg <= io_wdata_i;
      end
      if (wr_dat && (idx_reg == `EMP_IDX_CTL))
      begin
        ctl_reg <= io_wdata_i;
      end
      xfr_reg <= xfr_next;
    end
  end

  // Read transfers overwrite the staged word, so a later data write wins.
  always_comb
  begin
    xfr_next = xfr_reg;
    if (wr_dat && (idx_reg == `EMP_IDX_XFR))
    begin
      xfr_next = io_wdata_i;
    end
    else if (go_rd)
    begin
      xfr_next = src_val;
    end
  end

  // Descriptors and low-window boundaries load on the control write edge.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < `EMP_PAGES; i++)
      begin
        desc_reg[i] <= `EMP_BYTE_RST;
      end
      nclo_reg <= `EMP_BYTE_RST;
      nchi_reg <= `EMP_BYTE_RST;
    end
    else
    begin
      if (we_desc)
      begin
        desc_reg[ram_pg] <= xfr_reg;
      end
      if (go_wr && (dst == `EMP_DST_NCLO))
      begin
        nclo_reg <= xfr_reg;
      end
      if (go_wr && (dst == `EMP_DST_NCHI))
      begin
        nchi_reg <= xfr_reg;
      end
    end
  end

  // ****************************************************************
  // Fourteen-bit table registers
  // ****************************************************************
  // Four translation entries shared among all twenty-four pages.
  for (genvar g = 0; g < `EMP_ETRS; g++)
  begin : g_etr
    assign etr_if[g].wdata = xfr_reg;
    assign etr_if[g].we_lo = we_elo && (etr_sel == 2'(g));
    assign etr_if[g].we_hi = we_ehi && (etr_sel == 2'(g));
    assign etr_q[g]        = etr_if[g].q;
    emp_blk_reg #(.RST(`EMP_ETR_RST)) u_etr
    (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .r     (etr_if[g])
    );
  end

  // Upper cache limit, top of memory and remap upper limit.
  assign ucl_if.wdata = xfr_reg;
  assign ucl_if.we_lo = go_wr && (dst == `EMP_DST_UCL_LO);
  assign ucl_if.we_hi = go_wr && (dst == `EMP_DST_UCL_HI);
  assign tm_if.wdata  = xfr_reg;
  assign tm_if.we_lo  = go_wr && (dst == `EMP_DST_TM_LO);
  assign tm_if.we_hi  = go_wr && (dst == `EMP_DST_TM_HI);
  assign trm_if.wdata = xfr_reg;
  assign trm_if.we_lo = go_wr && (dst == `EMP_DST_TRM_LO);
  assign trm_if.we_hi = go_wr && (dst == `EMP_DST_TRM_HI);

  emp_blk_reg #(.RST(`EMP_UCL_RST)) u_ucl
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .r     (ucl_if)
  );

  emp_blk_reg #(.RST(`EMP_TM_RST)) u_tm
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .r     (tm_if)
  );

  emp_blk_reg #(.RST(`EMP_TRM_RST)) u_trm
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .r     (trm_if)
  );

  wire emp_blk_t ucl_q = ucl_if.q;
  wire emp_blk_t tm_q  = tm_if.q;
  wire emp_blk_t trm_q = trm_if.q;

  // ****************************************************************
  // Read-back selection
  // ****************************************************************
  // Source of a read transfer; unmapped sources return zero.
  wire emp_desc_t rd_desc = ram_ok ? desc_reg[ram_pg] : `EMP_BYTE_RST;
  wire emp_blk_t  rd_etr  = ram_ok ? etr_q[etr_sel] : '0;
  assign src_val =
    (dst == `EMP_DST_DESC)   ? rd_desc :
    (dst == `EMP_DST_ETR_LO) ? rd_etr[7:0] :
    (dst == `EMP_DST_ETR_HI) ? {2'b00, rd_etr[13:8]} :
    (dst == `EMP_DST_NCLO)   ? nclo_reg :
    (dst == `EMP_DST_NCHI)   ? nchi_reg :
    (dst == `EMP_DST_UCL_LO) ? ucl_q[7:0] :
    (dst == `EMP_DST_UCL_HI) ? {2'b00, ucl_q[13:8]} :
    (dst == `EMP_DST_TM_LO)  ? tm_q[7:0] :
    (dst == `EMP_DST_TM_HI)  ? {2'b00, tm_q[13:8]} :
    (dst == `EMP_DST_TRM_LO) ? trm_q[7:0] :
    (dst == `EMP_DST_TRM_HI) ? {2'b00, trm_q[13:8]} : `EMP_BYTE_RST;

  // Data port read of the selected index register.
  wire [7:0]  port_val =
    (idx_reg == `EMP_IDX_XFR) ? xfr_reg :
    (idx_reg == `EMP_IDX_ADR) ? ram_adr_reg :
    (idx_reg == `EMP_IDX_CTL) ? ctl_reg : `EMP_BYTE_RST;

  // ****************************************************************
  // Memory address decode
  // ****************************************************************
  wire         low_1m    = (mem_addr_i[27:`EMP_HI_LSB] == '0);
  wire [5:0]   seg       = mem_addr_i[`EMP_PG_MSB:`EMP_PG_LSB];
  wire         in_region = low_1m && (seg >= `EMP_SEG_BASE);
  wire [5:0]   pg_full   = seg - `EMP_SEG_BASE;
  wire [4:0]   pg        = pg_full[4:0];
  wire emp_desc_t cur    = in_region ? desc_reg[pg] : `EMP_BYTE_RST;
  wire emp_blk_t  blk    = mem_addr_i[27:`EMP_PG_LSB];

  // Window translation: entry supplies the block, the offset passes through.
  wire         is_win  = in_region && cur[`EMP_D_EMS];
  wire emp_blk_t  xblk = etr_q[pg[1:0]];
  wire [27:0]  xlat    = {xblk, mem_addr_i[`EMP_PG_LSB-1:0]};

  // Remap is live only when the remap limit exceeds top of memory.
  wire         remap_on = trm_q > tm_q;
  wire         blocked  = is_win && remap_on && (xblk >= tm_q) && (xblk < trm_q);

  // Shadow attributes count only without EMS and with the shadow bit set.
  wire         shd     = in_region && !cur[`EMP_D_EMS] && cur[`EMP_D_SHD];
  wire         shd_hit = mem_wr_i ? cur[`EMP_D_WR] : cur[`EMP_D_RD];

  wire emp_route_t route =
    is_win    ? (blocked ? EMP_GO_NONE : EMP_GO_DRAM) :
    shd       ? (shd_hit ? EMP_GO_DRAM : EMP_GO_ROM) :
    in_region ? EMP_GO_ROM :
    (blk < trm_q) ? EMP_GO_DRAM : EMP_GO_NONE;

  // Cacheability: any one source marking the address wins.
  wire [7:0]   nc_key  = mem_addr_i[`EMP_HI_LSB-1:`EMP_NC_LSB];
  wire         nc_low  = (nclo_reg != nchi_reg) && low_1m &&
                         (nc_key >= nclo_reg) && (nc_key < nchi_reg);
  wire         nc_top  = blk >= ucl_q;
  wire         nc_page = in_region && !cur[`EMP_D_CCH];
  wire         cache_ok = !(nc_low || nc_top || nc_page);

  // ****************************************************************
  // Output registers
  // ****************************************************************
  // Decisions are combinational from the address but leave through flops,
  // which costs one cycle of latency in exchange for clean output timing.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      io_rdata_o  <= `EMP_BYTE_RST;
      phys_addr_o <= '0;
      win_hit_o   <= 1'b0;
      dram_sel_o  <= 1'b0;
      rom_sel_o   <= 1'b0;
      cacheable_o <= 1'b0;
    end
    else
    begin
      io_rdata_o  <= rd_dat ? port_val : `EMP_BYTE_RST;
      phys_addr_o <= is_win ? xlat : mem_addr_i;
      win_hit_o   <= is_win;
      dram_sel_o  <= (route == EMP_GO_DRAM);
      rom_sel_o   <= (route == EMP_GO_ROM);
      cacheable_o <= cache_ok;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Select control index, then write the descriptor transfer command.
  sequence s_sel_ctl;
    wr_idx && (io_wdata_i == `EMP_IDX_CTL);
  endsequence
  sequence s_go_desc;
    wr_dat && (idx_reg == `EMP_IDX_CTL) && (io_wdata_i == `EMP_CTL_DESC_WR) && ram_ok;
  endsequence

  // Software may leave an idle cycle between the index and the data write.
  chk_table_write: assert property (s_sel_ctl ##[1:2] s_go_desc |=>
    desc_reg[$past(ram_pg)] == $past(xfr_reg))
    else $error("descriptor transfer did not store staged data");
  chk_index_sel: assert property (wr_idx |=> idx_reg == $past(io_wdata_i))
    else $error("index port write not captured");
  chk_ems_route: assert property (is_win && !blocked |=>
    win_hit_o && dram_sel_o && (phys_addr_o == $past(xlat)))
    else $error("window access not translated");
  chk_page_offset: assert property (win_hit_o |->
    phys_addr_o[`EMP_PG_LSB-1:0] == $past(mem_addr_i[`EMP_PG_LSB-1:0]))
    else $error("window offset not carried through");
  chk_page_base: assert property (low_1m && (seg == `EMP_SEG_BASE) |->
    in_region && (pg == 5'h00))
    else $error("segment A000 is not page zero");
  chk_entry_share: assert property (is_win |=>
    phys_addr_o[27:`EMP_PG_LSB] == $past(etr_q[pg % `EMP_ETRS]))
    else $error("page used the wrong translation entry");
  chk_no_remap: assert property (win_hit_o && dram_sel_o |->
    !($past(remap_on) && ($past(xblk) >= $past(tm_q)) && ($past(xblk) < $past(trm_q))))
    else $error("window reached remapped memory");
  chk_ems_prio: assert property (in_region && cur[`EMP_D_EMS] && cur[`EMP_D_SHD] |=>
    win_hit_o && !rom_sel_o)
    else $error("shadow attributes overrode window");
  chk_shadow_off: assert property (in_region && (cur[`EMP_D_EMS] == 1'b0) &&
    (cur[`EMP_D_SHD] == 1'b0) |=> rom_sel_o && !dram_sel_o)
    else $error("shadow bits acted with shadowing off");
  chk_copy_mode: assert property (in_region && (cur == 8'h05) |=>
    (dram_sel_o == $past(mem_wr_i)) && (rom_sel_o == !$past(mem_wr_i)))
    else $error("copy mode routed wrongly");
  chk_run_mode: assert property (in_region && (cur == 8'h0B) && !mem_wr_i |=>
    dram_sel_o && !rom_sel_o)
    else $error("shadow read not served from DRAM");
  chk_low_window: assert property (nc_low |=> !cacheable_o)
    else $error("low window address was cacheable");
  chk_limit_zero: assert property ((ucl_q == '0) [*2] |-> !cacheable_o)
    else $error("zero limit did not disable caching");
  chk_page_cache: assert property (nc_page |=> !cacheable_o)
    else $error("page cache bit ignored");
  chk_cache_all: assert property (!nc_low && !nc_top && !nc_page |=> cacheable_o)
    else $error("clean address not reported cacheable");

endmodule

/* inc/emp_params.svh */
`ifndef EMP_PARAMS_SVH
`define EMP_PARAMS_SVH

// ****************************************************************
// I/O ports and indices
// ****************************************************************
`define EMP_PORT_IDX     16'h0028
`define EMP_PORT_DAT     16'h0024
`define EMP_IDX_CTL      8'h28
`define EMP_IDX_ADR      8'h29
`define EMP_IDX_XFR      8'h2A
`define EMP_CTL_GO       7
`define EMP_CTL_WR       6
`define EMP_CTL_DESC_WR  8'hC3

// ****************************************************************
// Transfer destinations and sources
// ****************************************************************
`define EMP_DST_DESC     4'h3
`define EMP_DST_ETR_LO   4'h4
`define EMP_DST_ETR_HI   4'h5
`define EMP_DST_NCLO     4'h6
`define EMP_DST_NCHI     4'h7
`define EMP_DST_UCL_LO   4'h8
`define EMP_DST_UCL_HI   4'h9
`define EMP_DST_TM_LO    4'hA
`define EMP_DST_TM_HI    4'hB
`define EMP_DST_TRM_LO   4'hC
`define EMP_DST_TRM_HI   4'hD

// ****************************************************************
// Table geometry and address fields
// ****************************************************************
`define EMP_PAGES        24
`define EMP_ETRS         4
`define EMP_RAM_BASE     8'h08
`define EMP_RAM_TOP      8'h1F
`define EMP_SEG_BASE     6'h28
`define EMP_PG_LSB       14
`define EMP_PG_MSB       19
`define EMP_NC_LSB       12
`define EMP_HI_LSB       20

// ****************************************************************
// Page descriptor bits
// ****************************************************************
`define EMP_D_SHD        0
`define EMP_D_RD         1
`define EMP_D_WR         2
`define EMP_D_CCH        3
`define EMP_D_EMS        5

// ****************************************************************
// Reset values
// ****************************************************************
`define EMP_ETR_RST      14'h0040
`define EMP_UCL_RST      14'h0000
`define EMP_TM_RST       14'h0040
`define EMP_TRM_RST      14'h0040
`define EMP_BYTE_RST     8'h00

`endif

/* inc/emp_pkg.sv */
package emp_pkg;

  // ****************************************************************
  // Shared types
  // ****************************************************************
  typedef logic [13:0] emp_blk_t;
  typedef logic [7:0]  emp_desc_t;
  typedef enum logic [1:0] {EMP_GO_NONE, EMP_GO_DRAM, EMP_GO_ROM} emp_route_t;

endpackage

/* inc/emp_reg_if.sv */
`timescale 1ns/1ps
// Byte-wide write path to one 14-bit table register and its value.
interface emp_reg_if;
  logic [7:0]        wdata;
  logic              we_lo;
  logic              we_hi;
  emp_pkg::emp_blk_t q;
  modport ctl     (output wdata, output we_lo, output we_hi, input q);
  modport reg_side(input wdata, input we_lo, input we_hi, output q);
endinterface

/* verilog/emp_blk_reg.sv */
`timescale 1ns/1ps
// A 14-bit register loaded one byte at a time, low byte and high bits in either order.
module emp_blk_reg
  import emp_pkg::*;
#(
  parameter emp_blk_t RST = '0
)
(
  input  wire logic    clk_i,
  input  wire logic    rst_i,
  emp_reg_if.reg_side  r
);

  emp_blk_t val_reg;

  // Each byte lane loads on its own strobe; the upper lane keeps six bits.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      val_reg <= RST;
    end
    else
    begin
      if (r.we_lo)
      begin
        val_reg[7:0] <= r.wdata;
      end
      if (r.we_hi)
      begin
        val_reg[13:8] <= r.wdata[5:0];
      end
    end
  end

  assign r.q = val_reg;

endmodule

/* verification/emp_host_model.sv */
`timescale 1ns/1ps
`include "emp_params.svh"
// ****************************************************************
// Host software side of the index and data I/O ports
// ****************************************************************
module emp_host_model
(
  input  wire logic        clk_i,
  input  wire logic [7:0]  io_rdata_i,
  output logic             io_wr_o,
  output logic             io_rd_o,
  output logic      [15:0] io_addr_o,
  output logic      [7:0]  io_wdata_o
);
  // Strobes start low; idle lines never carry a port address.
  initial
  begin
    io_wr_o    = 1'b0;
    io_rd_o    = 1'b0;
    io_addr_o  = 16'hFFFF;
    io_wdata_o = 8'hFF;
  end

  // One write strobe; released lines show the inverse so stale values are never reused.
  task automatic io_write(input logic [15:0] a, input logic [7:0] d);
  begin
    @(posedge clk_i);
    io_wr_o    <= 1'b1;
    io_addr_o  <= a;
    io_wdata_o <= d;
    @(posedge clk_i);
    io_wr_o    <= 1'b0;
    io_addr_o  <= ~a;
    io_wdata_o <= ~d;
  end
  endtask

  // One read strobe at the data port; the answer stands for one cycle only.
  task automatic io_read(output logic [7:0] d);
  begin
    @(posedge clk_i);
    io_rd_o   <= 1'b1;
    io_addr_o <= `EMP_PORT_DAT;
    @(posedge clk_i);
    io_rd_o   <= 1'b0;
    io_addr_o <= ~`EMP_PORT_DAT;
    #1;
    d = io_rdata_i;
  end
  endtask

  // Index first, then the selected register.
  task automatic reg_write(input logic [7:0] idx, input logic [7:0] d);
  begin
    io_write(`EMP_PORT_IDX, idx);
    io_write(`EMP_PORT_DAT, d);
  end
  endtask

  // Stage table address, stage data, then fire a write transfer.
  task automatic tbl_write(input logic [7:0] ram, input logic [3:0] dst, input logic [7:0] d);
  begin
    reg_write(`EMP_IDX_ADR, ram);
    reg_write(`EMP_IDX_XFR, d);
    reg_write(`EMP_IDX_CTL, {4'hC, dst});
  end
  endtask

  // Read transfer into the staged data register, then read it back.
  task automatic tbl_read(input logic [7:0] ram, input logic [3:0] dst, output logic [7:0] d);
  begin
    reg_write(`EMP_IDX_ADR, ram);
    reg_write(`EMP_IDX_CTL, {4'h8, dst});
    io_write(`EMP_PORT_IDX, `EMP_IDX_XFR);
    io_read(d);
  end
  endtask
endmodule

/* verification/testbench.sv */
`timescale 1ns/1ps
`include "emp_params.svh"
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        io_wr_i, io_rd_i;
  logic [15:0] io_addr_i;
  logic [7:0]  io_wdata_i, io_rdata_o, rd_val;
  logic [27:0] mem_addr_i = 28'h0000000;
  logic        mem_wr_i = 1'b0;
  logic [27:0] phys_addr_o;
  logic        win_hit_o, dram_sel_o, rom_sel_o, cacheable_o;
  int          err_count = 0;
  int          n_checks = 0;

  // 200 MHz host clock.
  always #2.5 clk_i = ~clk_i;

  emp_decode emp_decode_inst (.clk_i(clk_i), .rst_i(rst_i), .io_wr_i(io_wr_i),
    .io_rd_i(io_rd_i), .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i),
    .mem_addr_i(mem_addr_i), .mem_wr_i(mem_wr_i), .io_rdata_o(io_rdata_o),
    .phys_addr_o(phys_addr_o), .win_hit_o(win_hit_o), .dram_sel_o(dram_sel_o),
    .rom_sel_o(rom_sel_o), .cacheable_o(cacheable_o));
  emp_host_model emp_host_model_inst (.clk_i(clk_i), .io_rdata_i(io_rdata_o),
    .io_wr_o(io_wr_i), .io_rd_o(io_rd_i), .io_addr_o(io_addr_i), .io_wdata_o(io_wdata_i));

  // ****************************************************************
  // Comparisons and shared bus cycles
  // ****************************************************************
  task automatic check_val(input string nm, input logic [27:0] e, input logic [27:0] g);
  begin
    n_checks++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  end
  endtask

  task automatic check_flag(input string nm, input logic e, input logic g);
  begin
    n_checks++;
    if (g !== e)
    begin
      $display("BAD %s expected %b seen %b", nm, e, g);
      err_count++;
    end
  end
  endtask

  // One memory cycle; flags are {hit, dram, rom, cache}, the address is checked with hit.
  task automatic mem_chk(input logic [27:0] a, input logic w, input logic [3:0] e,
                         input logic [3:0] m, input logic [27:0] ep);
  begin
    @(posedge clk_i);
    mem_addr_i <= a;
    mem_wr_i   <= w;
    @(posedge clk_i);
    #1;
    if (m[3]) check_flag("win_hit", e[3], win_hit_o);
    if (m[2]) check_flag("dram_sel", e[2], dram_sel_o);
    if (m[1]) check_flag("rom_sel", e[1], rom_sel_o);
    if (m[0]) check_flag("cacheable", e[0], cacheable_o);
    if (m[3]) check_val("phys_addr", ep, phys_addr_o);
  end
  endtask

  task automatic tbl_chk(input logic [7:0] ram, input logic [3:0] dst, input logic [7:0] e);
  begin
    emp_host_model_inst.tbl_read(ram, dst, rd_val);
    check_val("table", {20'h0, e}, {20'h0, rd_val});
  end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset;
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    check_val("outputs", 28'h0, {win_hit_o, dram_sel_o, rom_sel_o, cacheable_o});
    // First decoded cycle: low memory below the remap limit goes to DRAM, nothing cacheable.
    @(posedge clk_i);
    #1;
    check_val("outputs", 28'h4, {win_hit_o, dram_sel_o, rom_sel_o, cacheable_o});
    tbl_chk(8'h08, `EMP_DST_ETR_LO, 8'h40);
    tbl_chk(8'h08, `EMP_DST_ETR_HI, 8'h00);
    mem_chk(28'h0000100, 1'b0, 4'b0000, 4'b0001, 28'h0);
  end
  endtask

  task automatic test_window;
  begin
    emp_host_model_inst.tbl_write(8'h08, `EMP_DST_DESC, 8'h20);
    emp_host_model_inst.tbl_write(8'h08, `EMP_DST_ETR_HI, 8'h00);
    emp_host_model_inst.tbl_write(8'h08, `EMP_DST_ETR_LO, 8'h40);
    tbl_chk(8'h08, `EMP_DST_DESC, 8'h20);
    mem_chk(28'h00A0010, 1'b0, 4'b1100, 4'b1100, 28'h0100010);
    mem_chk(28'h009FFFC, 1'b0, 4'b0100, 4'b1100, 28'h009FFFC);
    emp_host_model_inst.tbl_write(8'h0C, `EMP_DST_DESC, 8'h20);
    mem_chk(28'h00B3FFE, 1'b0, 4'b1100, 4'b1100, 28'h0103FFE);
    emp_host_model_inst.tbl_write(8'h09, `EMP_DST_ETR_LO, 8'h23);
    emp_host_model_inst.tbl_write(8'h09, `EMP_DST_ETR_HI, 8'h01);
    emp_host_model_inst.tbl_write(8'h1D, `EMP_DST_DESC, 8'h20);
    mem_chk(28'h00F4ABC, 1'b0, 4'b1100, 4'b1100, {14'h0123, 14'h0ABC});
    emp_host_model_inst.tbl_write(8'h1F, `EMP_DST_DESC, 8'h20);
    mem_chk(28'h00FC004, 1'b0, 4'b1100, 4'b1100, 28'h0100004);
    emp_host_model_inst.tbl_write(8'h0A, `EMP_DST_DESC, 8'h27);
    mem_chk(28'h00A8100, 1'b1, 4'b1100, 4'b1110, 28'h0100100);
  end
  endtask

  // Page 8 is walked through the copy, run and disabled shadow settings.
  task automatic test_shadow;
  begin
    emp_host_model_inst.tbl_write(8'h10, `EMP_DST_DESC, 8'h05);
    mem_chk(28'h00C0100, 1'b0, 4'b0010, 4'b1110, 28'h00C0100);
    mem_chk(28'h00C0100, 1'b1, 4'b0100, 4'b1110, 28'h00C0100);
    emp_host_model_inst.tbl_write(8'h10, `EMP_DST_DESC, 8'h0B);
    mem_chk(28'h00C0100, 1'b0, 4'b0100, 4'b1110, 28'h00C0100);
    mem_chk(28'h00C0100, 1'b1, 4'b0010, 4'b1110, 28'h00C0100);
    emp_host_model_inst.tbl_write(8'h10, `EMP_DST_DESC, 8'h06);
    mem_chk(28'h00C0100, 1'b0, 4'b0010, 4'b1110, 28'h00C0100);
    mem_chk(28'h00C0100, 1'b1, 4'b0010, 4'b1110, 28'h00C0100);
  end
  endtask

  // Each non-cacheable source is opened and closed in turn.
  task automatic test_cache;
  begin
    emp_host_model_inst.tbl_write(8'h00, `EMP_DST_UCL_LO, 8'h00);
    emp_host_model_inst.tbl_write(8'h00, `EMP_DST_UCL_HI, 8'h04);
    tbl_chk(8'h00, `EMP_DST_UCL_HI, 8'h04);
    mem_chk(28'h0FFFFFC, 1'b0, 4'b0001, 4'b0001, 28'h0);
    mem_chk(28'h1000000, 1'b0, 4'b0000, 4'b0001, 28'h0);
    emp_host_model_inst.tbl_write(8'h10, `EMP_DST_DESC, 8'h0B);
    mem_chk(28'h00C0100, 1'b0, 4'b0001, 4'b0001, 28'h0);
    emp_host_model_inst.tbl_write(8'h10, `EMP_DST_DESC, 8'h03);
    mem_chk(28'h00C0100, 1'b0, 4'b0000, 4'b0001, 28'h0);
    mem_chk(28'h0010000, 1'b0, 4'b0001, 4'b0001, 28'h0);
    emp_host_model_inst.tbl_write(8'h00, `EMP_DST_NCLO, 8'h10);
    emp_host_model_inst.tbl_write(8'h00, `EMP_DST_NCHI, 8'h20);
    mem_chk(28'h0010000, 1'b0, 4'b0000, 4'b0001, 28'h0);
    mem_chk(28'h000FFFC, 1'b0, 4'b0001, 4'b0001, 28'h0);
    mem_chk(28'h0020000, 1'b0, 4'b0001, 4'b0001, 28'h0);
    emp_host_model_inst.tbl_write(8'h00, `EMP_DST_UCL_HI, 8'h00);
    mem_chk(28'h0200000, 1'b0, 4'b0000, 4'b0001, 28'h0);
  end
  endtask

  // Remap enabled so the window target lies in remapped space.
  task automatic test_remap;
  begin
    emp_host_model_inst.tbl_write(8'h00, `EMP_DST_TRM_LO, 8'h50);
    mem_chk(28'h00A0010, 1'b0, 4'b0000, 4'b0110, 28'h0);
    // Raising top of memory to the remap limit switches remap off again.
    emp_host_model_inst.tbl_write(8'h00, `EMP_DST_TM_LO, 8'h50);
    tbl_chk(8'h00, `EMP_DST_TM_LO, 8'h50);
    mem_chk(28'h00A0010, 1'b0, 4'b1100, 4'b1110, 28'h0100010);
  end
  endtask

  // ****************************************************************
  // Verdict, watchdog and main sequence
  // ****************************************************************
  task automatic finish_test;
  begin
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask

  // The whole run needs well under a thousand cycles; this allows ten times that.
  initial
  begin
    #50000;
    err_count++;
    finish_test();
  end

  initial
  begin
    test_reset();
    test_window();
    test_shadow();
    test_cache();
    test_remap();
    finish_test();
  end
endmodule
